/* pkg/flash_loader_pkg.sv */
// Package for the flash user system data loader.
// Holds memory map, field layout, reset values, states and carrier structs.
// Assumes a single 25 MHz clock domain and a 32-bit flash read port.
`default_nettype none

package flash_loader_pkg;

  // ****************************************
  // Memory map
  // ****************************************
  localparam logic [31:0] MAIN_BASE      = 32'h0800_0000;
  localparam int          SECTOR_SHIFT   = 10;
  localparam logic [6:0]  SECTORS_64K    = 7'h40;
  localparam logic [6:0]  SECTORS_32K    = 7'h20;
  localparam logic [31:0] BOOT_LO        = 32'h1FFF_E400;
  localparam logic [31:0] BOOT_HI        = 32'h1FFF_F3FF;
  localparam logic [31:0] USER_LO        = 32'h1FFF_F800;
  localparam logic [31:0] USER_HI        = 32'h1FFF_F9FF;
  localparam logic [1:0]  LAST_WORD      = 2'h3;

  // ****************************************
  // Item codes
  // ****************************************
  localparam logic [7:0]  FAP_OPEN       = 8'hA5;
  localparam logic [7:0]  FAP_HIGH       = 8'hCC;
  localparam logic [7:0]  ERASED_BYTE    = 8'hFF;

  // ****************************************
  // User data shadow layout
  // ****************************************
  localparam int          USD_ERR_BIT    = 0;
  localparam int          USD_PROT_BIT   = 1;
  localparam int          USD_SSB_LSB    = 2;
  localparam int          USD_DATA0_LSB  = 10;
  localparam int          USD_DATA1_LSB  = 18;
  localparam int          USD_HIGH_BIT   = 26;
  localparam int          SSB_WDOG_STDBY = 6;
  localparam int          SSB_WDOG_DSLP  = 5;
  localparam int          SSB_BOOT       = 4;
  localparam int          SSB_NORST_STBY = 2;
  localparam int          SSB_NORST_DSLP = 1;
  localparam int          SSB_WDOG_AUTO  = 0;
  localparam logic [31:0] USD_RESET      = 32'h0000_0000;
  localparam logic [31:0] EPPS_RESET     = 32'hFFFF_FFFF;

  // ****************************************
  // Register offsets and status bits
  // ****************************************
  localparam logic [7:0]  OFS_USD        = 8'h00;
  localparam logic [7:0]  OFS_EPPS       = 8'h04;
  localparam logic [7:0]  OFS_STATUS     = 8'h08;
  localparam logic [7:0]  OFS_PROBE_ADDR = 8'h0C;
  localparam logic [7:0]  OFS_PROBE_RES  = 8'h10;
  localparam int          STS_ERR_BIT    = 0;
  localparam int          STS_BUSY_BIT   = 1;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ST_ISSUE   = 3'b001,
    ST_CAPTURE = 3'b010,
    ST_DONE    = 3'b100
  } load_state_e;

  typedef enum logic [1:0] {
    REGION_NONE  = 2'h0,
    REGION_MAIN  = 2'h1,
    REGION_BOOT  = 2'h2,
    REGION_USER  = 2'h3
  } region_e;

  typedef enum logic [1:0] {
    BOOT_MAIN   = 2'h0,
    BOOT_SRAM   = 2'h1,
    BOOT_LOADER = 2'h2
  } boot_sel_e;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_s;

  typedef struct packed {
    region_e     region;
    logic [6:0]  sector;
  } region_s;

  typedef struct packed {
    logic wdog_run_in_standby;
    logic wdog_run_in_deepsleep;
    logic no_reset_on_standby;
    logic no_reset_on_deepsleep;
    logic wdog_auto_start_disable;
  } lowpower_cfg_s;

endpackage : flash_loader_pkg

`default_nettype wire

/* hdl/config_pair_check.sv */
// Integrity check of one value byte against its inverse byte.
// Purely combinational; the caller registers the result.
`default_nettype none

module config_pair_check
  import flash_loader_pkg::*;
(
  // Pair from the information block
  input  wire logic [7:0] i_value,
  input  wire logic [7:0] i_inverse,
  // Checked pair
  output logic      [7:0] o_value,
  output logic      [7:0] o_inverse,
  output logic            o_error
);

  logic erased;

  // ****************************************
  // Pair check
  // ****************************************
  // Fully erased pair is accepted as is
  assign erased    = (i_value == ERASED_BYTE) && (i_inverse == ERASED_BYTE);
  assign o_error   = (i_inverse != ~i_value) && !erased;
  // Corrupt pair is forced to erased
  assign o_value   = o_error ? ERASED_BYTE : i_value;
  assign o_inverse = o_error ? ERASED_BYTE : i_inverse;

endmodule : config_pair_check

`default_nettype wire

/* hdl/flash_user_data_loader.sv */
// Reset-time loader of user system data from the flash information block.
// Assumes a flash read port that returns a word the cycle after the strobe,
// and a register port with read data one cycle after the read strobe.
`default_nettype none

// Operation
// - 64 KB part: sixty-four 1 KB sectors upward from 0x0800_0000.
// - 32 KB part: thirty-two 1 KB sectors from the same base.
// - Boot loader region decoded at 0x1FFF_E400 to 0x1FFF_F3FF.
// - User data region decoded at 0x1FFF_F800 to 0x1FFF_F9FF.
// - Every system reset reloads user data and erase-protect shadows.
// - Each item is a value byte plus its inverse byte.
// - Bad pair sets error flag and forces both bytes to 0xFF; all-0xFF passes.
// - Region contents change shadows only at the next reset reload.
// - Access protect code in bits 7:0 of first word, inverse in 15:8.
// - 0xA5 open, 0xCC high level, others low level; enable in shadow bit 1.
// - High level protection disables the serial wire debug port at once.
// - Configuration byte from bits 23:16 goes to shadow bits 9:2.
// - Config bit 6: 0 stops watchdog in Standby, 1 keeps it counting.
// - Config bit 5: 0 stops watchdog in Deepsleep, 1 keeps it counting.
// - Config bit 4 with boot pin: 0 boots SRAM, 1 boots boot loader.
// - Config bit 2: 0 resets on Standby entry, 1 suppresses it.
// - Config bit 1: 0 resets on Deepsleep entry, 1 suppresses it.
// - Config bit 0: 0 starts watchdog after reset, 1 leaves it off.
module flash_user_data_loader
  import flash_loader_pkg::*;
(
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_reset,
  // Flash information block read port
  output logic               o_flash_rd,
  output logic        [31:0] o_flash_addr,
  input  wire logic   [31:0] i_flash_rd_data,
  // Straps
  input  wire logic          i_size_64k,
  input  wire logic          i_boot_pin,
  // Register port
  input  wire reg_req_s      i_reg_req,
  output logic        [31:0] o_reg_rdata,
  // Loaded configuration
  output logic               o_cpu_reset_hold,
  output logic               o_access_protect_en,
  output logic               o_high_protect,
  output logic               o_swd_disable,
  output logic               o_config_data_error_flag,
  output boot_sel_e          o_boot_sel,
  output lowpower_cfg_s      o_lowpower_cfg,
  output logic        [31:0] o_user_data_shadow,
  output logic        [31:0] o_erase_protect_shadow
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    load_state_e state;
    logic [1:0]  word_idx;
    logic [31:0] user_data_shadow;
    logic [31:0] erase_protect_shadow;
    logic        err_acc;
    logic        err_flag;
    logic [31:0] probe_addr;
    logic [31:0] rdata;
  } loader_s;

  loader_s    cur;
  loader_s    next_cur;
  logic [7:0] lo_val;
  logic [7:0] lo_inv;
  logic       lo_err;
  logic [7:0] hi_val;
  logic [7:0] hi_inv;
  logic       hi_err;
  logic       pass_err;
  region_s    probe_res;

  // ****************************************
  // Address decoding
  // ****************************************
  // Region and sector of a byte address
  function automatic region_s decode_region(input logic [31:0] addr, input logic size64);
    region_s     res;
    logic [31:0] ofs;
    logic [6:0]  sectors;
    res     = '{region: REGION_NONE, sector: 7'h00};
    ofs     = addr - MAIN_BASE;
    sectors = size64 ? SECTORS_64K : SECTORS_32K;
    if (addr >= MAIN_BASE && ofs[31:SECTOR_SHIFT] < {15'h0000, sectors}) begin
      res.region = REGION_MAIN;
      res.sector = ofs[SECTOR_SHIFT+6:SECTOR_SHIFT];
    end else if (addr >= BOOT_LO && addr <= BOOT_HI) begin
      res.region = REGION_BOOT;
    end else if (addr >= USER_LO && addr <= USER_HI) begin
      res.region = REGION_USER;
    end
    return res;
  endfunction : decode_region

  assign probe_res = decode_region(cur.probe_addr, i_size_64k);

  // ****************************************
  // Pair checkers
  // ****************************************
  // Low pair of the fetched word
  config_pair_check pair_lo (
    .i_value   (i_flash_rd_data[7:0]),
    .i_inverse (i_flash_rd_data[15:8]),
    .o_value   (lo_val),
    .o_inverse (lo_inv),
    .o_error   (lo_err)
  );

  // High pair of the fetched word
  config_pair_check pair_hi (
    .i_value   (i_flash_rd_data[23:16]),
    .i_inverse (i_flash_rd_data[31:24]),
    .o_value   (hi_val),
    .o_inverse (hi_inv),
    .o_error   (hi_err)
  );

  assign pass_err = cur.err_acc | lo_err | hi_err;

  // Corrupt pairs leave the checkers with value and inverse forced to erased
  pair_force_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_flash_rd_data[15:8] != ~i_flash_rd_data[7:0] && i_flash_rd_data[15:0] != 16'hFFFF)
    |-> lo_err && lo_val == ERASED_BYTE && lo_inv == ERASED_BYTE)
    else $error("corrupt low pair not forced to erased");

  pair_high_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_flash_rd_data[31:24] != ~i_flash_rd_data[23:16] && i_flash_rd_data[31:16] != 16'hFFFF)
    |-> hi_err && hi_val == ERASED_BYTE && hi_inv == ERASED_BYTE)
    else $error("corrupt high pair not forced to erased");

  // ****************************************
  // Next state
  // ****************************************
  // Loader sequence and register port
  always_comb begin
    next_cur       = cur;
    next_cur.rdata = 32'h0000_0000;
    case (cur.state)
      ST_ISSUE: begin
        next_cur.state = ST_CAPTURE;
      end
      ST_CAPTURE: begin
        next_cur.err_acc = pass_err;
        case (cur.word_idx)
          2'h0: begin
            // Protection level and configuration byte
            next_cur.user_data_shadow[USD_PROT_BIT] = (lo_val != FAP_OPEN);
            next_cur.user_data_shadow[USD_HIGH_BIT] = (lo_val == FAP_HIGH);
            next_cur.user_data_shadow[USD_SSB_LSB +: 8] = hi_val;
          end
          2'h1: begin
            next_cur.user_data_shadow[USD_DATA0_LSB +: 8] = lo_val;
            next_cur.user_data_shadow[USD_DATA1_LSB +: 8] = hi_val;
          end
          2'h2: begin
            next_cur.erase_protect_shadow[15:0] = {hi_val, lo_val};
          end
          default: begin
            next_cur.erase_protect_shadow[31:16] = {hi_val, lo_val};
          end
        endcase
        if (cur.word_idx == LAST_WORD) begin
          // Pass ends; flag reflects this pass only
          next_cur.state                          = ST_DONE;
          next_cur.err_flag                       = pass_err;
          next_cur.user_data_shadow[USD_ERR_BIT]  = pass_err;
        end else begin
          next_cur.word_idx = cur.word_idx + 2'h1;
          next_cur.state    = ST_ISSUE;
        end
      end
      ST_DONE: begin
        // Shadows frozen until the next reset
        next_cur.state = ST_DONE;
      end
      default: begin
        next_cur.state = ST_ISSUE;
      end
    endcase

    // Register writes
    if (i_reg_req.wr) begin
      if (i_reg_req.addr == OFS_PROBE_ADDR) begin
        next_cur.probe_addr = i_reg_req.wdata;
      end
    end

    // Register reads
    if (i_reg_req.rd) begin
      if (i_reg_req.addr == OFS_USD) begin
        next_cur.rdata = cur.user_data_shadow;
      end else if (i_reg_req.addr == OFS_EPPS) begin
        next_cur.rdata = cur.erase_protect_shadow;
      end else if (i_reg_req.addr == OFS_STATUS) begin
        next_cur.rdata[STS_ERR_BIT]  = cur.err_flag;
        next_cur.rdata[STS_BUSY_BIT] = (cur.state != ST_DONE);
      end else if (i_reg_req.addr == OFS_PROBE_ADDR) begin
        next_cur.rdata = cur.probe_addr;
      end else if (i_reg_req.addr == OFS_PROBE_RES) begin
        next_cur.rdata[8:0] = {probe_res.sector, probe_res.region};
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  // Every reset restarts the load pass
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cur.state                <= ST_ISSUE;
      cur.word_idx             <= 2'h0;
      cur.user_data_shadow     <= USD_RESET;
      cur.erase_protect_shadow <= EPPS_RESET;
      cur.err_acc              <= 1'b0;
      cur.err_flag             <= 1'b0;
      cur.probe_addr           <= 32'h0000_0000;
      cur.rdata                <= 32'h0000_0000;
    end else begin
      cur <= next_cur;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Flash fetch from the user data region
  assign o_flash_rd   = (cur.state == ST_ISSUE);
  assign o_flash_addr = USER_LO + {28'h000_0000, cur.word_idx, 2'b00};

  // Loaded settings
  assign o_reg_rdata              = cur.rdata;
  assign o_cpu_reset_hold         = (cur.state != ST_DONE);
  assign o_access_protect_en      = cur.user_data_shadow[USD_PROT_BIT];
  assign o_high_protect           = cur.user_data_shadow[USD_HIGH_BIT];
  assign o_swd_disable            = cur.user_data_shadow[USD_HIGH_BIT];
  assign o_config_data_error_flag = cur.err_flag;
  assign o_user_data_shadow       = cur.user_data_shadow;
  assign o_erase_protect_shadow   = cur.erase_protect_shadow;

  // Low power controls from the configuration byte
  assign o_lowpower_cfg.wdog_run_in_standby     = cur.user_data_shadow[USD_SSB_LSB + SSB_WDOG_STDBY];
  assign o_lowpower_cfg.wdog_run_in_deepsleep   = cur.user_data_shadow[USD_SSB_LSB + SSB_WDOG_DSLP];
  assign o_lowpower_cfg.no_reset_on_standby     = cur.user_data_shadow[USD_SSB_LSB + SSB_NORST_STBY];
  assign o_lowpower_cfg.no_reset_on_deepsleep   = cur.user_data_shadow[USD_SSB_LSB + SSB_NORST_DSLP];
  assign o_lowpower_cfg.wdog_auto_start_disable = cur.user_data_shadow[USD_SSB_LSB + SSB_WDOG_AUTO];

  // Boot source from boot pin and configuration bit
  always_comb begin
    if (!i_boot_pin) begin
      o_boot_sel = BOOT_MAIN;
    end else if (cur.user_data_shadow[USD_SSB_LSB + SSB_BOOT]) begin
      o_boot_sel = BOOT_LOADER;
    end else begin
      o_boot_sel = BOOT_SRAM;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  hold_through_pass_a: assert property ($past(i_reset) |-> o_cpu_reset_hold [*8] ##1 !o_cpu_reset_hold)
    else $error("processor reset not held for exactly the load pass");

  pass_done_a: assert property ((cur.state == ST_DONE) |-> !o_flash_rd && !o_cpu_reset_hold)
    else $error("flash fetched or reset held after the pass");

  bad_pair_a: assert property ((cur.state == ST_CAPTURE && cur.word_idx == LAST_WORD &&
                                i_flash_rd_data[15:8] != ~i_flash_rd_data[7:0] &&
                                i_flash_rd_data[15:0] != 16'hFFFF)
                               |=> cur.err_acc && cur.erase_protect_shadow[23:16] == ERASED_BYTE)
    else $error("corrupt pair not flagged or not forced to erased");

  erased_ok_a: assert property ((cur.state == ST_CAPTURE && i_flash_rd_data == 32'hFFFF_FFFF &&
                                 !cur.err_acc) |=> !cur.err_acc)
    else $error("erased word flagged as corrupt");

  open_code_a: assert property ((cur.state == ST_CAPTURE && cur.word_idx == 2'h0 &&
                                 i_flash_rd_data[15:0] == 16'h5AA5) |=> !o_access_protect_en)
    else $error("open code did not clear protection");

  high_swd_a: assert property ((cur.state == ST_CAPTURE && cur.word_idx == 2'h0 &&
                                i_flash_rd_data[15:0] == 16'h33CC) |=> o_swd_disable && o_access_protect_en)
    else $error("high level code did not disable debug");

  config_byte_a: assert property ((cur.state == ST_CAPTURE && cur.word_idx == 2'h0 && !hi_err)
                                  |=> o_user_data_shadow[9:2] == $past(i_flash_rd_data[23:16]))
    else $error("configuration byte not loaded into shadow");

  shadow_frozen_a: assert property ((cur.state == ST_DONE) |=>
                                    $stable(cur.user_data_shadow) && $stable(cur.erase_protect_shadow))
    else $error("shadow changed outside the reset pass");

  err_pass_a: assert property ((cur.state == ST_CAPTURE && cur.word_idx == LAST_WORD)
                               |=> o_config_data_error_flag == $past(pass_err))
    else $error("error flag does not match the pass result");

  fetch_region_a: assert property (o_flash_rd |-> o_flash_addr >= USER_LO && o_flash_addr <= USER_HI)
    else $error("fetch outside the user data region");

  boot_loader_a: assert property ((i_boot_pin && o_user_data_shadow[USD_SSB_LSB + SSB_BOOT])
                                  |-> o_boot_sel == BOOT_LOADER)
    else $error("boot loader not selected");

  // Main scenarios
  clean_pass_c:  cover property ($past(i_reset) ##8 (!o_cpu_reset_hold && !o_config_data_error_flag));
  error_pass_c:  cover property ((cur.state == ST_DONE) && o_config_data_error_flag);
  high_level_c:  cover property ((cur.state == ST_DONE) && o_swd_disable);
  probe_read_c:  cover property (i_reg_req.rd && i_reg_req.addr == OFS_PROBE_RES && probe_res.region == REGION_MAIN);

endmodule : flash_user_data_loader

`default_nettype wire

/* verification/info_block_model.sv */
// Behavioural model of the flash information block behind the loader.
// Assumes the loader strobes one word read and samples it the next cycle.
`default_nettype none

module info_block_model
  import flash_loader_pkg::*;
(
  // Clock
  input  wire logic             i_clk,
  // Read port from the loader
  input  wire logic             i_rd,
  input  wire logic [31:0]      i_addr,
  input  wire logic [3:0][31:0] i_image,
  // Returned word
  output logic      [31:0]      o_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Read response
  // ****************************************
  initial o_data = 32'h0000_0000;

  // Word stands one cycle only, then the bus toggles
  always @(posedge i_clk) begin
    if (i_rd && (i_addr[31:4] == USER_LO[31:4])) begin
      o_data <= i_image[i_addr[3:2]];
    end else begin
      o_data <= ~o_data;
    end
  end
endmodule : info_block_model

`default_nettype wire

/* verification/flash_user_data_loader_tb.sv */
// Self-checking bench for the user data loader.
// Assumes the info block model above and the register map of the hand-over.
`default_nettype none

module flash_user_data_loader_tb;
  import flash_loader_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Signals and instances
  // ****************************************
  logic             i_clk, i_reset, i_size_64k, i_boot_pin, fl_rd, hold, prot, high, swd, errf;
  logic [31:0]      fl_addr, fl_data, rdata, usd, epps;
  logic [3:0][31:0] image;
  reg_req_s         req;
  boot_sel_e        bsel;
  lowpower_cfg_s    lp;
  int               err_count, n_checks;

  flash_user_data_loader uut (.i_clk(i_clk), .i_reset(i_reset), .o_flash_rd(fl_rd), .o_flash_addr(fl_addr),
    .i_flash_rd_data(fl_data), .i_size_64k(i_size_64k), .i_boot_pin(i_boot_pin), .i_reg_req(req),
    .o_reg_rdata(rdata), .o_cpu_reset_hold(hold), .o_access_protect_en(prot), .o_high_protect(high),
    .o_swd_disable(swd), .o_config_data_error_flag(errf), .o_boot_sel(bsel), .o_lowpower_cfg(lp),
    .o_user_data_shadow(usd), .o_erase_protect_shadow(epps));
  info_block_model flash (.i_clk(i_clk), .i_rd(fl_rd), .i_addr(fl_addr), .i_image(image), .o_data(fl_data));

  // Clock, 40 ns period
  always #20 i_clk = ~i_clk;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  function automatic logic [15:0] pr(input logic [7:0] v);
    return {~v, v};
  endfunction : pr

  function automatic logic [3:0][31:0] img(input logic [7:0] access_protect_code, ssb, d0, d1, e0, e1, e2, e3);
    return {pr(e3), pr(e2), pr(e1), pr(e0), pr(d1), pr(d0), pr(ssb), pr(access_protect_code)};
  endfunction : img

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    req <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    req <= '0;
    #1 d = rdata;
  endtask : rd

  // Reset pulse, then wait for the pass to release the processor
  task automatic load(input logic [3:0][31:0] w);
    int n;
    @(posedge i_clk);
    image   <= w;
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    n = 0;
    do begin
      @(posedge i_clk);
      #1 n++;
    end while (hold !== 1'b0 && n < 40);
    if (n >= 40) begin
      err_count++;
      $display("MISMATCH t=%0t loader never finished", $time);
      conclude();
    end
    chk(32'(n >= 8 && n <= 9), 32'h0000_0001, "pass length");
  endtask : load

  // Compare every loaded output against values built from the items
  task automatic check_cfg(input logic [7:0] access_protect_code, ssb, d0, d1, input logic [31:0] e, input logic err);
    logic        p, h;
    logic [31:0] x, d;
    p = (access_protect_code != FAP_OPEN);
    h = (access_protect_code == FAP_HIGH);
    x = {5'h00, h, d1, d0, ssb, p, err};
    chk(usd, x, "user shadow");
    chk(epps, e, "erase shadow");
    chk({prot, high, swd}, {p, h, h}, "protect");
    chk(errf, err, "error flag");
    chk(lp.wdog_run_in_standby, ssb[6], "wdog standby");
    chk(lp.wdog_run_in_deepsleep, ssb[5], "wdog deepsleep");
    chk(lp.no_reset_on_standby, ssb[2], "standby reset");
    chk(lp.no_reset_on_deepsleep, ssb[1], "deepsleep reset");
    chk(lp.wdog_auto_start_disable, ssb[0], "wdog auto");
    @(posedge i_clk);
    i_boot_pin <= 1'b1;
    @(posedge i_clk);
    #1 chk(bsel, ssb[4] ? BOOT_LOADER : BOOT_SRAM, "boot high");
    @(posedge i_clk);
    i_boot_pin <= 1'b0;
    @(posedge i_clk);
    #1 chk(bsel, BOOT_MAIN, "boot low");
    rd(OFS_USD, d);
    chk(d, x, "usd read");
    rd(OFS_EPPS, d);
    chk(d, e, "epps read");
    rd(OFS_STATUS, d);
    chk(d, {30'h0, 1'b0, err}, "status read");
  endtask : check_cfg

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_clean();
    logic [3:0][31:0] w;
    w = img(8'hA5, 8'h75, 8'h12, 8'h00, 8'h01, 8'h02, 8'h04, 8'h08);
    w[1] = 32'hFFFF_FFFF;
    load(w);
    check_cfg(8'hA5, 8'h75, 8'hFF, 8'hFF, 32'h0804_0201, 1'b0);
    $display("test clean done");
  endtask : test_clean

  task automatic test_codes();
    logic [7:0] c [3] = '{8'hCC, 8'h00, 8'h5A};
    foreach (c[i]) begin
      load(img(c[i], 8'h0A, 8'h3C, 8'hC3, 8'h10, 8'h20, 8'h40, 8'h80));
      check_cfg(c[i], 8'h0A, 8'h3C, 8'hC3, 32'h8040_2010, 1'b0);
    end
    $display("test codes done");
  endtask : test_codes

  task automatic test_corrupt();
    logic [3:0][31:0] w;
    w = img(8'hA5, 8'h5A, 8'h11, 8'h22, 8'h01, 8'h02, 8'h33, 8'h04);
    w[0][31:24] = 8'h00;
    w[3][15:8]  = 8'h00;
    load(w);
    check_cfg(8'hA5, 8'hFF, 8'h11, 8'h22, 32'h04FF_0201, 1'b1);
    load(img(8'hA5, 8'h5A, 8'h11, 8'h22, 8'h01, 8'h02, 8'h33, 8'h04));
    check_cfg(8'hA5, 8'h5A, 8'h11, 8'h22, 32'h0433_0201, 1'b0);
    $display("test corrupt done");
  endtask : test_corrupt

  task automatic test_no_reload();
    @(posedge i_clk);
    image <= img(8'hCC, 8'h01, 8'h99, 8'h98, 8'h97, 8'h96, 8'h95, 8'h94);
    repeat (20) @(posedge i_clk);
    check_cfg(8'hA5, 8'h5A, 8'h11, 8'h22, 32'h0433_0201, 1'b0);
    load(image);
    check_cfg(8'hCC, 8'h01, 8'h99, 8'h98, 32'h9495_9697, 1'b0);
    $display("test no reload done");
  endtask : test_no_reload

  task automatic test_probe();
    logic [31:0] a [13] = '{32'h0800_0000, 32'h0800_FC00, 32'h0801_0000, 32'h0800_7C00, 32'h0800_8000,
      32'h1FFF_E3FF, 32'h1FFF_E400, 32'h1FFF_F3FF, 32'h1FFF_F400, 32'h1FFF_F800, 32'h1FFF_F9FF,
      32'h1FFF_FA00, 32'h0800_03FF};
    logic [12:0] big = 13'b1_1111_1110_0111;
    logic [8:0]  x [13] = '{9'h001, 9'h0FD, 9'h000, 9'h07D, 9'h000, 9'h000, 9'h002, 9'h002, 9'h000,
      9'h003, 9'h003, 9'h000, 9'h001};
    logic [31:0] d;
    foreach (a[i]) begin
      @(posedge i_clk);
      i_size_64k <= big[i];
      wr(OFS_PROBE_ADDR, a[i]);
      rd(OFS_PROBE_RES, d);
      chk(d, 32'(x[i]), "probe");
    end
    @(posedge i_clk);
    #1 chk(rdata, 32'h0000_0000, "read data one cycle");
    rd(8'h40, d);
    chk(d, 32'h0000_0000, "unmapped read");
    $display("test probe done");
  endtask : test_probe

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    i_clk      = 1'b0;
    i_reset    = 1'b1;
    i_size_64k = 1'b1;
    i_boot_pin = 1'b0;
    req        = '0;
    image      = img(8'hA5, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    err_count  = 0;
    n_checks   = 0;
    repeat (12) @(posedge i_clk);
    #1 chk(usd, USD_RESET, "usd in reset");
    chk(epps, EPPS_RESET, "epps in reset");
    chk(hold, 1'b1, "hold in reset");
    test_clean();
    test_codes();
    test_corrupt();
    test_no_reload();
    test_probe();
    conclude();
  end
endmodule : flash_user_data_loader_tb

`default_nettype wire
